// ===== core/apo_pkg.sv
package apo_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] APO_CFG_IDX = 8'h11;
    localparam logic [7:0] APO_STAT_IDX = 8'h26;
    localparam logic [7:0] APO_CTRL_IDX = 8'h30;
    localparam logic [7:0] APO_IRQS_IDX = 8'h31;
    localparam logic [7:0] APO_IRQM_IDX = 8'h32;
    localparam logic [7:0] APO_REC_IDX = 8'h33;
    localparam logic [7:0] APO_OPT_IDX = 8'h34;
    localparam int APO_MASK_LSB = 1;
    localparam int APO_MASK_W = 11;
    localparam int APO_DLY_LSB = 12;
    localparam int APO_DLY_W = 4;
    localparam int APO_HEALTHY_BIT = 11;
    localparam logic [15:0] APO_CFG_RST = 16'h0000;
    localparam logic APO_POL_RST = 1'b1;
    localparam int APO_CLK_HZ = 250000000;
    localparam int APO_SEC_CYCLES = APO_CLK_HZ;
    localparam logic [1:0] APO_RESP_OKAY = 2'h0;
    localparam logic [1:0] APO_RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic overvoltage;
        logic undervoltage;
        logic shortCircuit;
        logic excitationOvercurrent;
        logic underspeed;
        logic overspeed;
        logic underexcitation;
    } apo_alarms_t;
endpackage

// ===== core/apo_protection_output.sv
// Operation
// - Polarity set, no enabled alarm: contact closed (transistor on).
// - Polarity set: open once enabled alarm lasts the 0-15 s delay.
// - Supply loss opens the output at once, ignoring the delay.
// - Polarity clear: open normally and unpowered, closed after delay.
// - Active alarms with enable bit zero do not affect the output.
// - Config word: alarm mask in low bits, delay seconds in bits 12-15.
// - Mask weights 2 to 128 select the seven alarms; rest unassigned.
// - Running alarm-free: healthy indication high and status bit 11 high.
// - First alarm clears healthy and bit 11, stores operation time record.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module apo_protection_output #(
    parameter int SEC_CYCLES = apo_pkg::APO_SEC_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire apo_pkg::apo_alarms_t alarmIn,
    input wire logic supplyOk,
    output logic protectionOutputOn,
    output logic healthyIndication,
    output logic irq
);
    import apo_pkg::*;

    // =====================================================
    // Input synchronisers
    logic [7:0] syncA_reg, syncB_reg;
    logic [7:0] syncA_next, syncB_next;
    always_comb begin
        syncA_next = {supplyOk, alarmIn};
        syncB_next = syncA_reg;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_reg <= 8'h00;
            syncB_reg <= 8'h00;
        end else begin
            syncA_reg <= syncA_next;
            syncB_reg <= syncB_next;
        end
    end
    apo_alarms_t alarms;
    logic supplyGood;
    assign alarms = apo_alarms_t'(syncB_reg[6:0]);
    assign supplyGood = syncB_reg[7];

    // =====================================================
    // Registers and AXI4-Lite slave
    logic [15:0] cfg_reg, cfg_next;
    logic polarity_reg, polarity_next;
    logic [7:0] irqSt_reg, irqSt_next, irqMask_reg, irqMask_next;
    logic [31:0] rec_reg, rec_next, opTime_reg, opTime_next;
    logic awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
    logic [7:0] awIdx_reg, awIdx_next;
    logic [31:0] wData_reg, wData_next;
    logic [3:0] wStrb_reg, wStrb_next;
    logic bValid_reg, bValid_next, rValid_reg, rValid_next;
    logic [1:0] bResp_reg, bResp_next, rResp_reg, rResp_next;
    logic [31:0] rData_reg, rData_next;
    logic [15:0] statusWord;
    logic [10:0] enMask;
    logic [3:0] dlySec;
    logic [6:0] evtSet;
    logic doWrite;
    logic [7:0] arIdx;

    assign s_axi_awready = !awHeld_reg && !bValid_reg;
    assign s_axi_wready = !wHeld_reg && !bValid_reg;
    assign s_axi_arready = !rValid_reg;
    assign s_axi_bvalid = bValid_reg;
    assign s_axi_bresp = bResp_reg;
    assign s_axi_rvalid = rValid_reg;
    assign s_axi_rresp = rResp_reg;
    assign s_axi_rdata = rData_reg;
    assign doWrite = awHeld_reg && wHeld_reg && !bValid_reg;
    assign arIdx = s_axi_araddr[9:2];
    assign enMask = cfg_reg[APO_MASK_LSB +: APO_MASK_W];
    assign dlySec = cfg_reg[APO_DLY_LSB +: APO_DLY_W];
    assign irq = |(irqSt_reg & irqMask_reg);

    always_comb begin
        awHeld_next = awHeld_reg;
        wHeld_next = wHeld_reg;
        awIdx_next = awIdx_reg;
        wData_next = wData_reg;
        wStrb_next = wStrb_reg;
        bValid_next = bValid_reg;
        bResp_next = bResp_reg;
        rValid_next = rValid_reg;
        rResp_next = rResp_reg;
        rData_next = rData_reg;
        cfg_next = cfg_reg;
        polarity_next = polarity_reg;
        irqMask_next = irqMask_reg;
        irqSt_next = irqSt_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld_next = 1'b1;
            awIdx_next = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld_next = 1'b1;
            wData_next = s_axi_wdata;
            wStrb_next = s_axi_wstrb;
        end
        if (doWrite) begin
            awHeld_next = 1'b0;
            wHeld_next = 1'b0;
            bValid_next = 1'b1;
            bResp_next = APO_RESP_OKAY;
            if (awIdx_reg == APO_CFG_IDX) begin
                if (wStrb_reg[0]) cfg_next[7:0] = wData_reg[7:0];
                if (wStrb_reg[1]) cfg_next[15:8] = wData_reg[15:8];
            end else if (awIdx_reg == APO_CTRL_IDX) begin
                if (wStrb_reg[0]) polarity_next = wData_reg[0];
            end else if (awIdx_reg == APO_IRQS_IDX) begin
                if (wStrb_reg[0]) irqSt_next = irqSt_reg & ~wData_reg[7:0];
            end else if (awIdx_reg == APO_IRQM_IDX) begin
                if (wStrb_reg[0]) irqMask_next = wData_reg[7:0];
            end else if (awIdx_reg == APO_STAT_IDX ||
                         awIdx_reg == APO_REC_IDX ||
                         awIdx_reg == APO_OPT_IDX) begin
                bResp_next = APO_RESP_OKAY;
            end else begin
                bResp_next = APO_RESP_SLVERR;
            end
        end else if (bValid_reg && s_axi_bready) begin
            bValid_next = 1'b0;
        end
        // Set wins over a same-cycle clear
        irqSt_next = irqSt_next | {1'b0, evtSet};
        if (s_axi_arvalid && s_axi_arready) begin
            rValid_next = 1'b1;
            rResp_next = APO_RESP_OKAY;
            if (arIdx == APO_CFG_IDX) begin
                rData_next = {16'h0000, cfg_reg};
            end else if (arIdx == APO_STAT_IDX) begin
                rData_next = {16'h0000, statusWord};
            end else if (arIdx == APO_CTRL_IDX) begin
                rData_next = {31'h0, polarity_reg};
            end else if (arIdx == APO_IRQS_IDX) begin
                rData_next = {24'h000000, irqSt_reg};
            end else if (arIdx == APO_IRQM_IDX) begin
                rData_next = {24'h000000, irqMask_reg};
            end else if (arIdx == APO_REC_IDX) begin
                rData_next = rec_reg;
            end else if (arIdx == APO_OPT_IDX) begin
                rData_next = opTime_reg;
            end else begin
                rData_next = 32'h00000000;
                rResp_next = APO_RESP_SLVERR;
            end
        end else if (rValid_reg && s_axi_rready) begin
            rValid_next = 1'b0;
        end
    end

    write_answer_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        doWrite |=> s_axi_bvalid)
        else $error("write response missing");
    read_answer_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    read_error_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        s_axi_arvalid && s_axi_arready && arIdx > APO_OPT_IDX
        |=> s_axi_rresp == APO_RESP_SLVERR)
        else $error("unmapped read accepted");

    // =====================================================
    // Alarm delay timer and output
    logic [31:0] preCnt_reg, preCnt_next;
    logic [3:0] secCnt_reg, secCnt_next;
    logic tripped_reg, tripped_next;
    logic anyAlarm_reg, anyAlarm_next;
    logic healthy_reg, healthy_next;
    logic outOn_reg, outOn_next;
    logic [10:0] activeMap;
    logic enabledActive;
    logic anyAlarm;

    // weight 2 is field bit 0 after dropping bit 0 of the word
    assign activeMap = {4'h0, alarms.underexcitation, alarms.overspeed,
                        alarms.underspeed, alarms.excitationOvercurrent,
                        alarms.shortCircuit, alarms.undervoltage,
                        alarms.overvoltage};
    assign enabledActive = |(activeMap[10:0] & enMask);
    assign anyAlarm = |activeMap;
    assign evtSet = activeMap[6:0] & ~{7{anyAlarm_reg}};
    assign statusWord = {4'h0, healthy_reg, 11'h000};
    assign healthyIndication = healthy_reg;
    assign protectionOutputOn = outOn_reg;

    always_comb begin
        preCnt_next = preCnt_reg;
        secCnt_next = secCnt_reg;
        tripped_next = tripped_reg;
        opTime_next = opTime_reg + 32'h00000001;
        rec_next = rec_reg;
        anyAlarm_next = anyAlarm;
        healthy_next = !anyAlarm;
        if (anyAlarm && !anyAlarm_reg) begin
            rec_next = opTime_reg;
        end
        if (!enabledActive) begin
            preCnt_next = 32'h00000000;
            secCnt_next = 4'h0;
            tripped_next = 1'b0;
        end else if (secCnt_reg >= dlySec) begin
            tripped_next = 1'b1;
        end else if (preCnt_reg == 32'(SEC_CYCLES - 1)) begin
            preCnt_next = 32'h00000000;
            secCnt_next = secCnt_reg + 4'h1;
        end else begin
            preCnt_next = preCnt_reg + 32'h00000001;
        end
        // High means transistor conducts (contact closed)
        if (!supplyGood) begin
            outOn_next = 1'b0;
        end else if (polarity_reg) begin
            outOn_next = !tripped_next;
        end else begin
            outOn_next = tripped_next;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awIdx_reg <= 8'h00;
            wData_reg <= 32'h00000000;
            wStrb_reg <= 4'h0;
            bValid_reg <= 1'b0;
            bResp_reg <= 2'h0;
            rValid_reg <= 1'b0;
            rResp_reg <= 2'h0;
            rData_reg <= 32'h00000000;
            cfg_reg <= APO_CFG_RST;
            polarity_reg <= APO_POL_RST;
            irqSt_reg <= 8'h00;
            irqMask_reg <= 8'h00;
            preCnt_reg <= 32'h00000000;
            secCnt_reg <= 4'h0;
            tripped_reg <= 1'b0;
            opTime_reg <= 32'h00000000;
            rec_reg <= 32'h00000000;
            anyAlarm_reg <= 1'b0;
            healthy_reg <= 1'b0;
            outOn_reg <= 1'b0;
        end else begin
            awHeld_reg <= awHeld_next;
            wHeld_reg <= wHeld_next;
            awIdx_reg <= awIdx_next;
            wData_reg <= wData_next;
            wStrb_reg <= wStrb_next;
            bValid_reg <= bValid_next;
            bResp_reg <= bResp_next;
            rValid_reg <= rValid_next;
            rResp_reg <= rResp_next;
            rData_reg <= rData_next;
            cfg_reg <= cfg_next;
            polarity_reg <= polarity_next;
            irqSt_reg <= irqSt_next;
            irqMask_reg <= irqMask_next;
            preCnt_reg <= preCnt_next;
            secCnt_reg <= secCnt_next;
            tripped_reg <= tripped_next;
            opTime_reg <= opTime_next;
            rec_reg <= rec_next;
            anyAlarm_reg <= anyAlarm_next;
            healthy_reg <= healthy_next;
            outOn_reg <= outOn_next;
        end
    end

    // =====================================================
    // Assertions
    sequence alarmOnsetS;
        supplyGood && enabledActive && !tripped_reg && dlySec == 4'h0;
    endsequence
    sequence timerRunningS;
        enabledActive && !tripped_reg && secCnt_reg < dlySec;
    endsequence
    supply_loss_a: assert property (
        @(posedge mclk) disable iff (!rst_n) !supplyGood |=> !outOn_reg)
        else $error("output not open");
    closed_normal_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        supplyGood && polarity_reg && !enabledActive |=> outOn_reg)
        else $error("contact not closed");
    inverted_normal_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        supplyGood && !polarity_reg && !enabledActive |=> !outOn_reg)
        else $error("inverted contact closed");
    // Polarity may be rewritten at the same edge, so use its old value
    zero_delay_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        alarmOnsetS |=> outOn_reg != $past(polarity_reg))
        else $error("zero delay late");
    masked_alarm_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (activeMap & enMask) == 11'h000 |=> !tripped_reg)
        else $error("masked alarm tripped");
    timer_restart_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !enabledActive |=> secCnt_reg == 4'h0 && preCnt_reg == 32'h0)
        else $error("timer kept");
    trip_delay_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $rose(tripped_reg) |-> secCnt_reg >= dlySec)
        else $error("tripped early");
    no_early_trip_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        timerRunningS |=> !tripped_reg)
        else $error("tripped before delay");
    healthy_bit_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !anyAlarm |=> healthyIndication && statusWord[APO_HEALTHY_BIT])
        else $error("healthy not set");
    healthy_drop_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        anyAlarm |=> !healthyIndication && !statusWord[APO_HEALTHY_BIT])
        else $error("healthy kept");
    record_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        anyAlarm && !anyAlarm_reg |=>
        rec_reg == $past(opTime_reg) && !healthyIndication)
        else $error("record missing");
    event_set_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        evtSet != 7'h00 |=>
        (irqSt_reg[6:0] & $past(evtSet)) == $past(evtSet))
        else $error("event bit lost");
endmodule
`default_nettype wire

// ===== sim/apo_contact_sense.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Supervision input that senses the open-collector contact
module apo_contact_sense (
    input wire logic protectionOutputOn,
    output logic contactClosed,
    output logic senseLine
);
    // Pull-up on the sense line; only a conducting transistor sinks it
    assign senseLine = protectionOutputOn ? 1'b0 : 1'b1;
    assign contactClosed = ~senseLine;
endmodule
`default_nettype wire

// ===== sim/apo_protection_output_tb.sv
`timescale 1ns/100ps
`default_nettype none
module apo_protection_output_tb;
    import apo_pkg::*;
    // Short second keeps the 15 s delay within a few hundred cycles
    localparam int SEC = 10;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic supplyOk = 1'b1;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd, rec;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, outOn, healthy, irq;
    logic contactClosed, senseLine;
    logic [1:0] bresp, rresp, rsp;
    apo_alarms_t alarmIn = '0;
    int n_fail = 0;
    int num_checks = 0;
    int n;

    always #2 mclk = ~mclk;

    apo_protection_output #(.SEC_CYCLES(SEC)) DUT (
        .mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .alarmIn(alarmIn), .supplyOk(supplyOk),
        .protectionOutputOn(outOn), .healthyIndication(healthy), .irq(irq)
    );
    apo_contact_sense sensor (.protectionOutputOn(outOn),
        .contactClosed(contactClosed), .senseLine(senseLine));

    // ======================================================
    // Reporting
    task automatic conclude();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic hang();
        n_fail++;
        conclude();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkIn(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got,
                     lo, hi);
        end
    endtask

    // ======================================================
    // Bus access; handshakes are judged at the falling edge before
    // the rising edge that completes them, so nothing races the clock
    task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                      output logic [1:0] resp);
        bit a, w, done;
        done = 0;
        @(posedge mclk);
        awaddr <= {22'h0, idx, 2'h0};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(negedge mclk);
            a = awvalid && awready;
            w = wvalid && wready;
            done = bvalid;
            resp = bresp;
            @(posedge mclk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (done) bready <= 1'b0;
        end
        if (!done) hang();
    endtask
    task automatic rdReg(input logic [7:0] idx, output logic [31:0] d,
                         output logic [1:0] resp);
        bit a, done;
        done = 0;
        @(posedge mclk);
        araddr <= {22'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(negedge mclk);
            a = arvalid && arready;
            done = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge mclk);
            if (a) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
        if (!done) hang();
    endtask
    task automatic wrOk(input logic [7:0] idx, input logic [31:0] d);
        wr(idx, d, rsp);
        chk(rsp, APO_RESP_OKAY);
    endtask
    task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp);
        rdReg(idx, rd, rsp);
        chk(rd, exp);
        chk(rsp, APO_RESP_OKAY);
    endtask

    // ======================================================
    // Output timing
    task automatic settle(input int k);
        repeat (k) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic waitOut(input logic v, output int c);
        c = 0;
        while (outOn !== v && c < 400) begin
            @(negedge mclk);
            c++;
        end
        if (c >= 400) hang();
    endtask
    task automatic trip(input apo_alarms_t a, input logic v, input int lo,
                        input int hi);
        int c;
        @(posedge mclk);
        alarmIn <= a;
        waitOut(v, c);
        chkIn(c, lo, hi);
    endtask
    // Output must hold its level for k cycles after the alarm change
    task automatic stay(input apo_alarms_t a, input logic v, input int k);
        int bad;
        bad = 0;
        @(posedge mclk);
        alarmIn <= a;
        repeat (k) begin
            @(negedge mclk);
            if (outOn !== v) bad++;
        end
        chk(bad, 0);
    endtask

    // ======================================================
    // Scenarios
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        settle(4);
        rdChk(APO_CFG_IDX, 32'h0);
        rdReg(APO_STAT_IDX, rd, rsp);
        chk(rd[APO_HEALTHY_BIT], 1'b1);
        chk(healthy, 1'b1);
        chk(contactClosed, 1'b1);
        rdChk(APO_CTRL_IDX, 32'h1);
        wrOk(APO_CFG_IDX, 32'hF0FC);
        stay(7'h40, 1'b1, 400);
        chk(healthy, 1'b0);
        rdReg(APO_STAT_IDX, rd, rsp);
        chk(rd[APO_HEALTHY_BIT], 1'b0);
        chk(irq, 1'b0);
        wrOk(APO_IRQM_IDX, 32'h7F);
        chk(irq, 1'b1);
        rdChk(APO_IRQS_IDX, 32'h01);
        wrOk(APO_IRQS_IDX, 32'h01);
        chk(irq, 1'b0);
        rdReg(APO_REC_IDX, rec, rsp);
        rdReg(APO_OPT_IDX, rd, rsp);
        chk(rec != 0 && rec < rd, 1'b1);
        stay('0, 1'b1, 40);
        chk(healthy, 1'b1);
        for (int i = 0; i < 7; i++) begin
            wrOk(APO_CFG_IDX, 32'h1 << (7 - i));
            trip(apo_alarms_t'(7'h01 << i), 1'b0, 2, 5);
            trip('0, 1'b1, 2, 5);
        end
        wrOk(APO_CFG_IDX, 32'h3002);
        trip(7'h40, 1'b0, 3 * SEC + 2, 3 * SEC + 5);
        trip('0, 1'b1, 2, 5);
        stay(7'h40, 1'b1, 20);
        trip('0, 1'b1, 0, 0);
        settle(5);
        trip(7'h40, 1'b0, 3 * SEC + 2, 3 * SEC + 5);
        wrOk(APO_CFG_IDX, 32'hF002);
        trip('0, 1'b1, 2, 5);
        trip(7'h40, 1'b0, 15 * SEC + 2, 15 * SEC + 5);
        trip('0, 1'b1, 2, 5);
        stay(7'h40, 1'b1, 20);
        @(posedge mclk);
        supplyOk <= 1'b0;
        waitOut(1'b0, n);
        chkIn(n, 2, 5);
        @(posedge mclk);
        supplyOk <= 1'b1;
        trip('0, 1'b1, 2, 5);
        wrOk(APO_CTRL_IDX, 32'h0);
        settle(6);
        chk(contactClosed, 1'b0);
        wrOk(APO_CFG_IDX, 32'h1002);
        trip(7'h40, 1'b1, SEC + 2, SEC + 5);
        trip('0, 1'b0, 2, 5);
        trip(7'h40, 1'b1, SEC + 2, SEC + 5);
        @(posedge mclk);
        supplyOk <= 1'b0;
        waitOut(1'b0, n);
        chkIn(n, 2, 5);
        chk(senseLine, 1'b1);
        rdReg(8'h3F, rd, rsp);
        chk(rsp, APO_RESP_SLVERR);
        chk(rd, 32'h0);
        wr(8'h3F, 32'h1, rsp);
        chk(rsp, APO_RESP_SLVERR);
        conclude();
    end
endmodule
`default_nettype wire
